// ===== verilog/ucrb_defs.vh
`ifndef UCRB_DEFS_VH
`define UCRB_DEFS_VH
// ********************************************************
// base addresses and register offsets
// ********************************************************
`define UCRB_BASE_COM1     10'h3F8
`define UCRB_BASE_COM2     10'h2F8
`define UCRB_BASE_COM3     10'h3E8
`define UCRB_BASE_COM4     10'h2E8
`define UCRB_BASE_MASK     10'h3F8
`define UCRB_OFF_DATA      3'h0
`define UCRB_OFF_IER       3'h1
`define UCRB_OFF_IIR       3'h2
`define UCRB_OFF_LCR       3'h3
`define UCRB_OFF_MCR       3'h4
`define UCRB_OFF_LSR       3'h5
`define UCRB_OFF_MSR       3'h6
// ********************************************************
// fields and reset values
// ********************************************************
`define UCRB_DAS_BIT       7
`define UCRB_IER_MASK      8'h0F
`define UCRB_IE_RX         0
`define UCRB_IE_TX         1
`define UCRB_IE_LS         2
`define UCRB_IE_MDM        3
`define UCRB_LSR_DR        0
`define UCRB_LSR_THRE      5
`define UCRB_LSR_TEMT      6
`define UCRB_LSR_ERR_LO    1
`define UCRB_LSR_ERR_HI    4
`define UCRB_ZERO8         8'h00
`define UCRB_IIR_NONE      8'h01
`define UCRB_IIR_LS        8'h06
`define UCRB_IIR_RX        8'h04
`define UCRB_IIR_TX        8'h02
`define UCRB_IIR_MDM       8'h00
`define UCRB_FIFO_W        8
`define UCRB_FIFO_D        4
`endif

// ===== verilog/ucrb_fifo.v
module ucrb_fifo #(
  parameter W = 8,
  parameter D = 4
) (
  input  wire         i_ref_clk,
  input  wire         i_nrst,
  input  wire [W-1:0] i_data,
  input  wire         i_valid,
  output wire         o_ready,
  output wire [W-1:0] o_data,
  output wire         o_valid,
  input  wire         i_ready
);
  // ********************************************************
  // storage, pointers and fill count
  // ********************************************************
  reg [W-1:0] mem [0:D-1];
  reg [1:0]   wr_q;
  reg [1:0]   rd_q;
  reg [2:0]   cnt_q;
  wire        push = i_valid && (cnt_q != D);
  wire        pop  = i_ready && (cnt_q != 3'h0);

  assign o_ready = (cnt_q != D);
  assign o_valid = (cnt_q != 3'h0);
  assign o_data  = mem[rd_q];

  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
    if (!i_nrst) begin
      wr_q  <= 2'h0;
      rd_q  <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 2'h1;
      end
      if (pop) begin
        rd_q <= rd_q + 2'h1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 3'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
endmodule // ucrb_fifo

// ===== verilog/ucrb_regs.v
`include "ucrb_defs.vh"
// Function
// (RULE_01) decode one of four jumper-selected base addresses, registers at fixed offsets
// (RULE_02) line control bit 7 selects which register answers at shared offsets
// (RULE_03) write offset 0 with select clear loads outgoing character
// (RULE_04) read offset 0 with select clear returns latest received character
// (RULE_05) select set: offsets 0 and 1 are read/write divisor bytes
// (RULE_06) divisor is 16 bits, stored only, no timing derived
// (RULE_07) interrupt enable upper four bits always read zero
// (RULE_08) four low enable bits gate four interrupt types, read back
// (RULE_09) enable bit 3 gates modem status interrupt, any status bit 0..3
// (RULE_10) enable bit 2 gates line status interrupt, line status bits 1..4
// (RULE_11) enable bit 1 gates transmit-empty interrupt when device can accept
// (RULE_12) enable bit 0 gates receive-available interrupt when character stored
// (RULE_13) ident 2, line control 3, modem control 4, line status 5, modem 6
// (RULE_14) interrupt request high while any enabled condition active
// (RULE_15) enables and divisor access select reset to zero
module ucrb_regs (
  input  wire       i_ref_clk,
  input  wire       i_nrst,
  input  wire [1:0] i_base_sel,
  input  wire [9:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_iow,
  input  wire       i_ior,
  output reg  [7:0] o_rdata,
  output reg        o_rdata_en,
  output reg        o_irq,
  output reg  [7:0] o_tx_data,
  output reg        o_tx_valid,
  input  wire       i_tx_ready,
  input  wire [7:0] i_rx_data,
  input  wire       i_rx_valid,
  input  wire [3:0] i_modem_events,
  input  wire [3:0] i_line_errors,
  output reg  [7:0] o_modem_ctrl,
  output reg  [7:0] o_line_ctrl
);
  // ********************************************************
  // pin synchronisers
  // ********************************************************
  // commands keep a third flop so each strobe is taken on its rising edge
  reg [1:0] base_s1_q;
  reg [1:0] base_s2_q;
  reg [9:0] addr_s1_q;
  reg [9:0] addr_s2_q;
  reg [7:0] wd_s1_q;
  reg [7:0] wd_s2_q;
  reg       iow_s1_q;
  reg       iow_s2_q;
  reg       iow_s3_q;
  reg       ior_s1_q;
  reg       ior_s2_q;
  reg       ior_s3_q;
  reg [7:0] rxd_s1_q;
  reg [7:0] rxd_s2_q;
  reg       rxv_s1_q;
  reg       rxv_s2_q;
  reg       txr_s1_q;
  reg       txr_s2_q;
  reg [3:0] mdm_s1_q;
  reg [3:0] mdm_s2_q;
  reg [3:0] le_s1_q;
  reg [3:0] le_s2_q;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      base_s1_q <= 2'h0;
      base_s2_q <= 2'h0;
      addr_s1_q <= 10'h000;
      addr_s2_q <= 10'h000;
      wd_s1_q   <= 8'h00;
      wd_s2_q   <= 8'h00;
      iow_s1_q  <= 1'b0;
      iow_s2_q  <= 1'b0;
      iow_s3_q  <= 1'b0;
      ior_s1_q  <= 1'b0;
      ior_s2_q  <= 1'b0;
      ior_s3_q  <= 1'b0;
      rxd_s1_q  <= 8'h00;
      rxd_s2_q  <= 8'h00;
      rxv_s1_q  <= 1'b0;
      rxv_s2_q  <= 1'b0;
      txr_s1_q  <= 1'b0;
      txr_s2_q  <= 1'b0;
      mdm_s1_q  <= 4'h0;
      mdm_s2_q  <= 4'h0;
      le_s1_q   <= 4'h0;
      le_s2_q   <= 4'h0;
    end else begin
      base_s1_q <= i_base_sel;
      base_s2_q <= base_s1_q;
      addr_s1_q <= i_addr;
      addr_s2_q <= addr_s1_q;
      wd_s1_q   <= i_wdata;
      wd_s2_q   <= wd_s1_q;
      iow_s1_q  <= i_iow;
      iow_s2_q  <= iow_s1_q;
      iow_s3_q  <= iow_s2_q;
      ior_s1_q  <= i_ior;
      ior_s2_q  <= ior_s1_q;
      ior_s3_q  <= ior_s2_q;
      rxd_s1_q  <= i_rx_data;
      rxd_s2_q  <= rxd_s1_q;
      rxv_s1_q  <= i_rx_valid;
      rxv_s2_q  <= rxv_s1_q;
      txr_s1_q  <= i_tx_ready;
      txr_s2_q  <= txr_s1_q;
      mdm_s1_q  <= i_modem_events;
      mdm_s2_q  <= mdm_s1_q;
      le_s1_q   <= i_line_errors;
      le_s2_q   <= le_s1_q;
    end
  end

  // ********************************************************
  // address decode
  // ********************************************************
  function [9:0] base_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    base_of = `UCRB_BASE_COM1;
        2'h1:    base_of = `UCRB_BASE_COM2;
        2'h2:    base_of = `UCRB_BASE_COM3;
        default: base_of = `UCRB_BASE_COM4;
      endcase
    end
  endfunction

  // strobes taken once, on the rising edge of the synchronised command
  wire       hit   = ((addr_s2_q & `UCRB_BASE_MASK) == base_of(base_s2_q)); // RULE_01
  wire [2:0] off   = addr_s2_q[2:0];
  wire       wr_ev = iow_s2_q && !iow_s3_q && hit;
  wire       rd_ev = ior_s2_q && !ior_s3_q && hit;

  // ********************************************************
  // registers
  // ********************************************************
  reg  [7:0] lcr_q;
  reg  [7:0] mcr_q;
  reg  [7:0] ier_q;
  reg  [7:0] dll_q;
  reg  [7:0] dlh_q;
  reg  [7:0] rbr_q;
  reg  [7:0] lsr_err_q;
  reg        rx_full_q;
  reg        tx_room_q;
  reg        rx_tog_q;
  reg  [7:0] lsr;
  wire       das = lcr_q[`UCRB_DAS_BIT]; // RULE_02
  wire       mdm_act = |mdm_s2_q; // RULE_09
  wire       ls_act = |lsr_err_q[`UCRB_LSR_ERR_HI:`UCRB_LSR_ERR_LO]; // RULE_10

  // both transmit-empty bits follow queue room; there is no shift stage
  always @* begin
    lsr = `UCRB_ZERO8;
    lsr[`UCRB_LSR_DR] = rx_full_q;
    lsr[`UCRB_LSR_ERR_HI:`UCRB_LSR_ERR_LO] = lsr_err_q[`UCRB_LSR_ERR_HI:`UCRB_LSR_ERR_LO];
    lsr[`UCRB_LSR_THRE] = tx_room_q;
    lsr[`UCRB_LSR_TEMT] = tx_room_q;
  end
  wire       fifo_ready;
  reg        push_q;
  reg  [7:0] push_data_q;
  wire [7:0] f_data;
  wire       f_valid;

  // ********************************************************
  // transmit queue and bus-side stage
  // ********************************************************
  // four-deep queue decouples host writes from the bus-side handshake
  ucrb_fifo #(
    .W (`UCRB_FIFO_W),
    .D (`UCRB_FIFO_D)
  ) u_txq (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_data    (push_data_q),
    .i_valid   (push_q),
    .o_ready   (fifo_ready),
    .o_data    (f_data),
    .o_valid   (f_valid),
    .i_ready   (!o_tx_valid || txr_s2_q)
  );

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      lcr_q       <= `UCRB_ZERO8; // RULE_15
      ier_q       <= `UCRB_ZERO8; // RULE_15
      mcr_q       <= `UCRB_ZERO8;
      dll_q       <= `UCRB_ZERO8;
      dlh_q       <= `UCRB_ZERO8;
      rbr_q       <= `UCRB_ZERO8;
      lsr_err_q   <= `UCRB_ZERO8;
      rx_full_q   <= 1'b0;
      rx_tog_q    <= 1'b0;
      tx_room_q   <= 1'b1;
      push_q      <= 1'b0;
      push_data_q <= `UCRB_ZERO8;
      o_tx_valid  <= 1'b0;
      o_tx_data   <= `UCRB_ZERO8;
    end else begin
      push_q <= 1'b0;
      // line errors are sticky until line status is read; set wins
      lsr_err_q <= ((rd_ev && off == `UCRB_OFF_LSR) ? `UCRB_ZERO8 : lsr_err_q)
                   | {3'h0, le_s2_q, 1'b0}; // RULE_10
      // received character stored; a new one beats the read clear
      rx_tog_q <= rxv_s2_q;
      if (rxv_s2_q && !rx_tog_q) begin
        rbr_q     <= rxd_s2_q;
        rx_full_q <= 1'b1; // RULE_12
      end else if (rd_ev && off == `UCRB_OFF_DATA && !das) begin
        rx_full_q <= 1'b0;
      end
      tx_room_q <= fifo_ready && !push_q; // RULE_11
      if (wr_ev) begin
        case (off)
          `UCRB_OFF_DATA: begin
            if (das) begin
              dll_q <= wd_s2_q; // RULE_05
            end else begin
              push_q      <= fifo_ready; // RULE_03
              push_data_q <= wd_s2_q;
            end
          end
          `UCRB_OFF_IER: begin
            if (das) begin
              dlh_q <= wd_s2_q; // RULE_05
            end else begin
              ier_q <= wd_s2_q & `UCRB_IER_MASK; // RULE_07
            end
          end
          `UCRB_OFF_LCR: lcr_q <= wd_s2_q;
          `UCRB_OFF_MCR: mcr_q <= wd_s2_q;
          default: ;
        endcase
      end
      // bus-side output stage: hold until the device takes it
      if (!o_tx_valid || txr_s2_q) begin
        o_tx_valid <= f_valid;
        o_tx_data  <= f_data;
      end
    end
  end

  // ********************************************************
  // interrupt identification and read mux
  // ********************************************************
  wire [3:0] act = {mdm_act, ls_act, tx_room_q, rx_full_q};
  wire [3:0] pend = act & ier_q[3:0]; // RULE_08
  reg  [7:0] iir;
  reg  [7:0] rmux;

  always @* begin
    if (pend[`UCRB_IE_LS]) begin
      iir = `UCRB_IIR_LS;
    end else if (pend[`UCRB_IE_RX]) begin
      iir = `UCRB_IIR_RX;
    end else if (pend[`UCRB_IE_TX]) begin
      iir = `UCRB_IIR_TX;
    end else if (pend[`UCRB_IE_MDM]) begin
      iir = `UCRB_IIR_MDM;
    end else begin
      iir = `UCRB_IIR_NONE;
    end
    case (off) // RULE_13
      `UCRB_OFF_DATA: rmux = das ? dll_q : rbr_q; // RULE_04
      `UCRB_OFF_IER:  rmux = das ? dlh_q : ier_q; // RULE_05
      `UCRB_OFF_IIR:  rmux = iir;
      `UCRB_OFF_LCR:  rmux = lcr_q;
      `UCRB_OFF_MCR:  rmux = mcr_q;
      `UCRB_OFF_LSR:  rmux = lsr;
      `UCRB_OFF_MSR:  rmux = {4'h0, mdm_s2_q};
      default:        rmux = `UCRB_ZERO8;
    endcase
  end

  // ********************************************************
  // registered outputs
  // ********************************************************
  // divisor bytes never reach any timing logic; storage only (RULE_06)
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_rdata      <= `UCRB_ZERO8;
      o_rdata_en   <= 1'b0;
      o_irq        <= 1'b0;
      o_modem_ctrl <= `UCRB_ZERO8;
      o_line_ctrl  <= `UCRB_ZERO8;
    end else begin
      o_rdata_en   <= ior_s2_q && hit;
      // taken once at the read edge so a clear-on-read cannot alter it
      if (rd_ev) begin
        o_rdata <= rmux;
      end else if (!(ior_s2_q && hit)) begin
        o_rdata <= `UCRB_ZERO8;
      end
      o_irq        <= |pend; // RULE_14
      o_modem_ctrl <= mcr_q;
      o_line_ctrl  <= lcr_q;
    end
  end
endmodule // ucrb_regs

// ===== dv/ucrb_regs_checker.sv
module ucrb_regs_checker (
  input wire       i_ref_clk,
  input wire       i_nrst,
  input wire [1:0] i_base_sel,
  input wire [9:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_iow,
  input wire       i_ior,
  input wire [7:0] o_rdata,
  input wire       o_rdata_en,
  input wire [7:0] o_tx_data,
  input wire       o_tx_valid,
  input wire       i_tx_ready,
  input wire [7:0] o_modem_ctrl,
  input wire [7:0] o_line_ctrl
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // decode seen at the pins
  // ********
  // base select folded into address bits 8 and 4
  wire       hit = i_addr[9:3] == {1'b1, ~i_base_sel[0], 3'h7, ~i_base_sel[1], 1'b1};
  wire [2:0] off = i_addr[2:0];
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_read;
    $rose(i_ior) && hit ##1 (i_ior && $stable(i_addr))[*3];
  endsequence
  sequence s_lcr_wr;
    (i_iow && hit && off == 3'h3)[*5];
  endsequence
  sequence s_mcr_wr;
    (i_iow && hit && off == 3'h4)[*5];
  endsequence
  a_read_answer: assert property (s_read |-> o_rdata_en)
    else $error("read at own base not answered");
  a_other_base: assert property ((i_ior && !hit)[*6] |-> !o_rdata_en)
    else $error("read at foreign address answered");
  a_read_quiet: assert property (!o_rdata_en |-> o_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_ier_upper: assert property (o_rdata_en && off == 3'h1 && !o_line_ctrl[7] |-> o_rdata[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  a_reset_quiet: assert property (disable iff (1'b0) !i_nrst |=> o_line_ctrl == 8'h00 && !o_tx_valid)
    else $error("outputs not cleared by reset");
  a_tx_hold: assert property ((o_tx_valid && !i_tx_ready)[*3] |=> o_tx_valid && $stable(o_tx_data))
    else $error("outgoing char dropped before accept");
  a_tx_launch: assert property ($rose(i_iow) && hit && off == 3'h0 && !o_line_ctrl[7] && !o_tx_valid |-> ##[1:8] o_tx_valid)
    else $error("written char not offered");
  a_lcr_write: assert property (s_lcr_wr |-> o_line_ctrl == i_wdata)
    else $error("line control not loaded");
  a_mcr_write: assert property (s_mcr_wr |-> o_modem_ctrl == i_wdata)
    else $error("modem control not loaded");
endmodule // ucrb_regs_checker

bind ucrb_regs ucrb_regs_checker u_chk (.i_ref_clk, .i_nrst, .i_base_sel, .i_addr, .i_wdata,
  .i_iow, .i_ior, .o_rdata, .o_rdata_en, .o_tx_data, .o_tx_valid, .i_tx_ready, .o_modem_ctrl,
  .o_line_ctrl);

// ===== dv/ucrb_far.sv
module ucrb_far (
  input  wire        i_ref_clk,
  input  wire  [7:0] i_tx_data,
  input  wire        i_tx_valid,
  output logic       o_tx_ready = 1'b0,
  output logic [7:0] o_rx_data = 8'hA5,
  output logic       o_rx_valid = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // bus device side
  // ********
  logic [7:0] got[$];
  // one char per pulse, then rest so the synced ready cannot count twice
  always begin
    @(negedge i_ref_clk);
    if (i_tx_valid) begin
      repeat ($urandom % 4) @(negedge i_ref_clk);
      o_tx_ready = 1'b1;
      @(posedge i_ref_clk);
      got.push_back(i_tx_data);
      @(negedge i_ref_clk);
      o_tx_ready = 1'b0;
      repeat (4) @(negedge i_ref_clk);
    end
  end
  task put(input logic [7:0] c);
    @(negedge i_ref_clk);
    o_rx_data = c;
    o_rx_valid = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    o_rx_valid = 1'b0;
    o_rx_data = ~c;
  endtask
endmodule // ucrb_far

// ===== dv/uart_compatible_register_bank_bench.sv
module uart_compatible_register_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_ref_clk = 0, i_nrst = 0, i_iow = 0, i_ior = 0, o_rdata_en, o_irq, o_tx_valid;
  logic [1:0] i_base_sel = 0;
  logic [9:0] i_addr = 0, bas = 10'h3F8;
  logic [7:0] i_wdata = 0, o_rdata, o_tx_data, o_modem_ctrl, o_line_ctrl, i_rx_data;
  logic [7:0] m_lcr = 0, m_mcr = 0, m_ier = 0, m_rx = 0, m_st = 0, m_dl[2], txq[$];
  logic [3:0] i_modem_events = 0, i_line_errors = 0;
  logic       i_tx_ready, i_rx_valid;
  int         errors = 0, n_tests = 0, k;
  always #12.5 i_ref_clk = ~i_ref_clk;
  ucrb_regs DUT (.i_ref_clk, .i_nrst, .i_base_sel, .i_addr, .i_wdata, .i_iow, .i_ior, .o_rdata,
    .o_rdata_en, .o_irq, .o_tx_data, .o_tx_valid, .i_tx_ready, .i_rx_data, .i_rx_valid,
    .i_modem_events, .i_line_errors, .o_modem_ctrl, .o_line_ctrl);
  ucrb_far FAR (.i_ref_clk, .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
    .o_tx_ready(i_tx_ready), .o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid));
  // ********
  // model, bus cycles, checks
  // ********
  task chk(input string nm, input logic [7:0] e, s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task wrap_up;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function logic [9:0] at(input logic [2:0] o);
    at = {bas[9:3], o};
  endfunction
  function logic [7:0] ex(input logic [2:0] o);
    case (o)
      3'h0: ex = m_lcr[7] ? m_dl[0] : m_rx;
      3'h1: ex = m_lcr[7] ? m_dl[1] : m_ier;
      3'h3: ex = m_lcr;
      3'h4: ex = m_mcr;
      3'h7: ex = 8'h00;
      default: ex = m_st;
    endcase
  endfunction
  task wr(input logic [2:0] o, input logic [7:0] v);
    @(negedge i_ref_clk);
    i_addr = at(o);
    i_wdata = v;
    i_iow = 1;
    repeat (5) @(negedge i_ref_clk);
    i_iow = 0;
    repeat (3) @(negedge i_ref_clk);
    case (o)
      3'h0: if (m_lcr[7]) m_dl[0] = v; else txq.push_back(v);
      3'h1: if (m_lcr[7]) m_dl[1] = v; else m_ier = v & 8'h0F;
      3'h3: m_lcr = v;
      default: m_mcr = v;
    endcase
  endtask
  // read held a little past the answer so the data can settle
  task rc(input logic [9:0] a, input logic hit, input string nm);
    @(negedge i_ref_clk);
    i_addr = a;
    i_ior = 1;
    for (k = 0; k < 8 && o_rdata_en !== 1'b1; k++) @(negedge i_ref_clk);
    repeat (2) @(negedge i_ref_clk);
    chk(nm, {7'h00, hit}, {7'h00, o_rdata_en});
    if (hit && o_rdata_en !== 1'b1) wrap_up;
    if (hit) chk(nm, ex(a[2:0]), o_rdata);
    i_ior = 0;
    repeat (3) @(negedge i_ref_clk);
  endtask
  task irqc(input logic e, input string nm);
    repeat (6) @(negedge i_ref_clk);
    chk(nm, {7'h00, e}, {7'h00, o_irq});
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    errors++;
    $display("BAD run exp end got hang");
    wrap_up;
  end
  initial begin
    k = $urandom(32'h525F);
    repeat (3) @(negedge i_ref_clk);
    i_nrst = 1;
    rc(at(3'h1), 1, "ier_rst");
    rc(at(3'h3), 1, "lcr_rst");
    for (int s = 0; s < 4; s++) begin
      i_base_sel = s[1:0];
      bas = {1'b1, ~i_base_sel[0], 3'h7, ~i_base_sel[1], 4'h8};
      repeat (4) @(negedge i_ref_clk);
      wr(3'h3, 8'($urandom) & 8'h7F);
      rc(at(3'h3), 1, "lcr");
      chk("lcr_out", m_lcr, o_line_ctrl);
      wr(3'h4, 8'($urandom));
      rc(at(3'h4), 1, "mcr");
      chk("mcr_out", m_mcr, o_modem_ctrl);
      rc(bas ^ 10'h100, 0, "other_base");
    end
    wr(3'h3, 8'h83);
    wr(3'h0, 8'($urandom));
    wr(3'h1, 8'($urandom));
    rc(at(3'h0), 1, "div_lo");
    rc(at(3'h1), 1, "div_hi");
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hFF);
    rc(at(3'h1), 1, "ier");
    repeat (6) wr(3'h0, 8'($urandom));
    repeat (40) @(negedge i_ref_clk);
    chk("tx_count", 8'(txq.size()), 8'(FAR.got.size()));
    foreach (txq[i]) chk("tx_char", txq[i], FAR.got[i]);
    wr(3'h1, 8'h00);
    irqc(0, "irq_off");
    wr(3'h1, 8'h02);
    irqc(1, "irq_tx");
    wr(3'h1, 8'h01);
    irqc(0, "irq_rx_idle");
    m_rx = 8'($urandom);
    FAR.put(m_rx);
    irqc(1, "irq_rx");
    rc(at(3'h0), 1, "rx_char");
    irqc(0, "irq_rx_clr");
    wr(3'h1, 8'h08);
    i_modem_events = 4'h4;
    irqc(1, "irq_ms");
    wr(3'h1, 8'h04);
    i_line_errors = 4'h2;
    irqc(1, "irq_ls");
    m_st = 8'h06;
    rc(at(3'h2), 1, "iir");
    m_st = 8'h64;
    rc(at(3'h5), 1, "lsr");
    m_st = 8'h04;
    rc(at(3'h6), 1, "msr");
    rc(at(3'h7), 1, "off7");
    i_nrst = 0;
    repeat (3) @(negedge i_ref_clk);
    i_nrst = 1;
    m_ier = 0;
    m_lcr = 0;
    irqc(0, "irq_rst");
    rc(at(3'h1), 1, "ier_rst2");
    rc(at(3'h3), 1, "lcr_rst2");
    wrap_up;
  end
endmodule // uart_compatible_register_bank_bench
